// >>> scwd_decoder.sv
/*
 * Serial command word decoder: shifts in a chip-select framed 32-bit word
 * on the host serial clock, hands it to the system clock, scales the value
 * by a power of ten and routes it to one of five settings.
 * Assumes serClk only toggles while csN is low, and the word register is
 * left untouched while csN is high, so it is stable when read after the
 * synchronised chip-select rise.
 */
`timescale 1ns/100ps

module scwd_decoder (
   input  wire logic                    sys_clk,
   input  wire logic                    reset_n,
   input  wire logic                    serClk,
   input  wire logic                    serData,
   input  wire logic                    csN,
   output scwd_pkg::scwd_settings_t     settings,
   output logic [scwd_pkg::FREQ_W-1:0]  freqHz,
   output logic                         wordAccepted,
   output logic                         wordDiscarded
);

   // Ten to the power n, n from 0 to 15
   function automatic logic [scwd_pkg::POW_W-1:0] pow10(
      input logic [scwd_pkg::EXP_W-1:0] n
   );
      logic [scwd_pkg::POW_W-1:0] r;
      r = 50'h1;
      for (int i = 0; i < scwd_pkg::MAX_EXP; i++)
      begin
         if (i < int'(n))
         begin
            r = scwd_pkg::POW_W'(r * 50'hA);
         end
      end
      return r;
   endfunction : pow10

   // Value times ten to the exponent
   function automatic logic [scwd_pkg::SET_W-1:0] scaleValue(
      input scwd_pkg::scwd_cmd_t c
   );
      return scwd_pkg::SET_W'(scwd_pkg::SET_W'(c.valueField) *
                              scwd_pkg::SET_W'(pow10(c.decadeExp)));
   endfunction : scaleValue

   // ---------------- Link domain ----------------
   logic [scwd_pkg::WORD_BITS-1:0] shiftQ;
   logic [scwd_pkg::WORD_BITS-1:0] shiftD;
   logic [scwd_pkg::CNT_W-1:0]     bitCntQ;
   logic [scwd_pkg::CNT_W-1:0]     bitCntD;
   logic                           armQ;
   logic                           armSet;
   logic                           cntClrQ;
   logic                           cntRst;

   // Frame start marker, set while chip select is high
   assign armSet = csN | ~reset_n;

   // Count cleared once the word is taken, so a frame without clocks is refused
   assign cntRst = cntClrQ | ~reset_n;

   always_comb
   begin
      shiftD  = shiftQ;
      bitCntD = bitCntQ;
      if (!csN)
      begin
         shiftD = {shiftQ[scwd_pkg::WORD_BITS-2:0], serData};
         if (armQ)
         begin
            bitCntD = scwd_pkg::CNT_ONE;
         end
         else if (bitCntQ != scwd_pkg::CNT_SAT)
         begin
            bitCntD = scwd_pkg::CNT_W'(bitCntQ + scwd_pkg::CNT_ONE);
         end
      end
   end

   always_ff @(posedge serClk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         shiftQ  <= '0;
      end
      else
      begin
         shiftQ  <= shiftD;
      end
   end

   // Cleared from the system side only while chip select is high and the link is quiet
   always_ff @(posedge serClk or posedge cntRst)
   begin
      if (cntRst)
      begin
         bitCntQ <= scwd_pkg::CNT_RST;
      end
      else
      begin
         bitCntQ <= bitCntD;
      end
   end

   always_ff @(posedge serClk or posedge armSet)
   begin
      if (armSet)
      begin
         armQ <= 1'b1;
      end
      else
      begin
         armQ <= 1'b0;
      end
   end

   // ---------------- System domain ----------------
   logic                     csMetaQ;
   logic                     csSyncQ;
   logic                     csPrevQ;
   logic                     csRise;
   scwd_pkg::scwd_state_t    stateQ;
   scwd_pkg::scwd_state_t    stateD;
   scwd_pkg::scwd_cmd_t      wordQ;
   scwd_pkg::scwd_cmd_t      wordD;
   logic [scwd_pkg::SET_W-1:0] scaledQ;
   logic [scwd_pkg::SET_W-1:0] scaledD;
   scwd_pkg::scwd_settings_t setQ;
   scwd_pkg::scwd_settings_t setD;
   logic [scwd_pkg::FREQ_W-1:0] freqD;
   logic                     acceptD;
   logic                     discardD;
   logic                     cntClrD;

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         csMetaQ <= 1'b1;
         csSyncQ <= 1'b1;
         csPrevQ <= 1'b1;
      end
      else
      begin
         csMetaQ <= csN;
         csSyncQ <= csMetaQ;
         csPrevQ <= csSyncQ;
      end
   end

   assign csRise = csSyncQ & ~csPrevQ;

   always_comb
   begin
      stateD   = stateQ;
      wordD    = wordQ;
      scaledD  = scaledQ;
      setD     = setQ;
      acceptD  = 1'b0;
      discardD = 1'b0;
      cntClrD  = csRise;
      freqD    = scwd_pkg::FREQ_W'(setQ.start) +
                 scwd_pkg::FREQ_W'(scwd_pkg::FREQ_W'(setQ.channel) *
                                   scwd_pkg::FREQ_W'(setQ.step));
      case (stateQ)
         scwd_pkg::ST_IDLE:
         begin
            if (csRise)
            begin
               if (bitCntQ == scwd_pkg::CNT_FULL)
               begin
                  wordD  = scwd_pkg::scwd_cmd_t'(shiftQ);
                  stateD = scwd_pkg::ST_SCALE;
               end
               else
               begin
                  discardD = 1'b1;
               end
            end
         end
         scwd_pkg::ST_SCALE:
         begin
            scaledD = scaleValue(wordQ);
            stateD  = scwd_pkg::ST_ROUTE;
         end
         scwd_pkg::ST_ROUTE:
         begin
            acceptD = 1'b1;
            case (wordQ.routeCode)
               scwd_pkg::RT_CHANNEL:   setD.channel   = scaledQ;
               scwd_pkg::RT_START:     setD.start     = scaledQ;
               scwd_pkg::RT_STOP:      setD.stop      = scaledQ;
               scwd_pkg::RT_STEP:      setD.step      = scaledQ;
               scwd_pkg::RT_REFERENCE: setD.reference = scaledQ;
               default:
               begin
                  acceptD  = 1'b0;
                  discardD = 1'b1;
               end
            endcase
            stateD = scwd_pkg::ST_IDLE;
         end
         default:
         begin
            stateD = scwd_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stateQ            <= scwd_pkg::ST_IDLE;
         wordQ             <= '0;
         scaledQ           <= '0;
         setQ.channel      <= scwd_pkg::PRESET_CHANNEL;
         setQ.start        <= scwd_pkg::PRESET_START;
         setQ.stop         <= scwd_pkg::PRESET_STOP;
         setQ.step         <= scwd_pkg::PRESET_STEP;
         setQ.reference    <= scwd_pkg::PRESET_REFERENCE;
         freqHz            <= '0;
         wordAccepted      <= 1'b0;
         wordDiscarded     <= 1'b0;
         cntClrQ           <= 1'b0;
      end
      else
      begin
         stateQ            <= stateD;
         wordQ             <= wordD;
         scaledQ           <= scaledD;
         setQ              <= setD;
         freqHz            <= freqD;
         wordAccepted      <= acceptD;
         wordDiscarded     <= discardD;
         cntClrQ           <= cntClrD;
      end
   end

   assign settings = setQ;

   // ---------------- Assertions ----------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence s_scale_then_route;
      stateQ == scwd_pkg::ST_SCALE ##1 stateQ == scwd_pkg::ST_ROUTE;
   endsequence

   sequence s_full_rise;
      csRise && stateQ == scwd_pkg::ST_IDLE && bitCntQ == scwd_pkg::CNT_FULL;
   endsequence

   a_latch_full_word: assert property (
      s_full_rise |=> s_scale_then_route ##1 (wordAccepted || wordDiscarded))
      else $error("Full word not decoded after chip select rise");

   a_short_frame_drop: assert property (
      csRise && stateQ == scwd_pkg::ST_IDLE && bitCntQ != scwd_pkg::CNT_FULL
      |=> wordDiscarded && stateQ == scwd_pkg::ST_IDLE && $stable(setQ))
      else $error("Short frame was not discarded");

   a_word_fields: assert property (
      s_full_rise |=> wordQ.valueField == $past(shiftQ[23:0]) &&
                      wordQ.routeCode == $past(shiftQ[31:28]))
      else $error("Word fields not taken from the shifted bits");

   a_scale_value: assert property (
      stateQ == scwd_pkg::ST_SCALE |=>
      scaledQ == scwd_pkg::SET_W'(scwd_pkg::SET_W'(wordQ.valueField) *
                                  scwd_pkg::SET_W'(pow10(wordQ.decadeExp))))
      else $error("Scaled value mismatch");

   a_decade_low: assert property (
      stateQ == scwd_pkg::ST_SCALE && wordQ.decadeExp == 4'h3 |=>
      scaledQ == scwd_pkg::SET_W'(scwd_pkg::SET_W'(wordQ.valueField) * 74'h3E8))
      else $error("Exponent three did not scale by one thousand");

   a_route_start: assert property (
      stateQ == scwd_pkg::ST_ROUTE && wordQ.routeCode == scwd_pkg::RT_START
      |=> setQ.start == $past(scaledQ) && $stable(setQ.channel) && wordAccepted)
      else $error("Start setting not loaded with scaled value");

   a_route_channel: assert property (
      stateQ == scwd_pkg::ST_ROUTE && wordQ.routeCode == scwd_pkg::RT_CHANNEL
      |=> setQ.channel == $past(scaledQ) && $stable(setQ.step))
      else $error("Channel setting not loaded with scaled value");

   a_reserved_hold: assert property (
      stateQ == scwd_pkg::ST_ROUTE && wordQ.routeCode > scwd_pkg::RT_REFERENCE
      |=> $stable(setQ) && wordDiscarded && !wordAccepted)
      else $error("Reserved code changed a setting");

   a_freq_formula: assert property (
      $past(reset_n) |-> freqHz == scwd_pkg::FREQ_W'($past(setQ.start)) +
         scwd_pkg::FREQ_W'(scwd_pkg::FREQ_W'($past(setQ.channel)) *
                           scwd_pkg::FREQ_W'($past(setQ.step))))
      else $error("Frequency does not follow start plus channel times step");

   a_idle_no_write: assert property (
      stateQ != scwd_pkg::ST_ROUTE |=> $stable(setQ))
      else $error("Setting written outside the routing step");

   a_count_clear: assert property (
      csRise |=> bitCntQ == scwd_pkg::CNT_RST)
      else $error("Bit count not cleared after the word was taken");

endmodule : scwd_decoder

// >>> scwd_decoder_bench.sv
/*
 * Self-checking bench of the serial command word decoder.
 * Assumes the host model as the only driver of the serial link.
 */
`timescale 1ns/100ps

`define CHK(got, exp) \
   begin \
      totalChecks++; \
      if ((got) !== (exp)) \
      begin \
         fails++; \
         $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); \
      end \
   end

module scwd_decoder_bench;

   localparam int FW = scwd_pkg::FREQ_W;
   localparam int SW = scwd_pkg::SET_W;
   localparam logic [3:0]  RTS [6] = '{4'h3, 4'h1, 4'h0, 4'h2, 4'h4, 4'h0};
   localparam logic [3:0]  EXS [6] = '{4'h3, 4'h6, 4'h0, 4'hF, 4'h1, 4'h2};
   localparam logic [23:0] VLS [6] = '{24'h19, 24'hC5D, 24'h7, 24'hFFFFFF, 24'h1E8480,
                                       24'hABCDE};

   logic                     sys_clk;
   logic                     reset_n;
   logic                     serClk;
   logic                     serData;
   logic                     csN;
   scwd_pkg::scwd_settings_t settings;
   scwd_pkg::scwd_settings_t expS;
   logic [FW-1:0]            freqHz;
   logic                     wordAccepted;
   logic                     wordDiscarded;
   int                       fails;
   int                       totalChecks;

   scwd_decoder u_scwd_decoder (
      .sys_clk       (sys_clk),
      .reset_n       (reset_n),
      .serClk        (serClk),
      .serData       (serData),
      .csN           (csN),
      .settings      (settings),
      .freqHz        (freqHz),
      .wordAccepted  (wordAccepted),
      .wordDiscarded (wordDiscarded)
   );

   scwd_host_model u_scwd_host_model (
      .serClk  (serClk),
      .serData (serData),
      .csN     (csN)
   );

   initial
   begin
      sys_clk     = 1'b0;
      reset_n     = 1'b0;
      fails       = 0;
      totalChecks = 0;
   end

   always #10 sys_clk = ~sys_clk;

   // Value times ten to the n, truncated to the setting width
   function automatic logic [SW-1:0] scaled(input logic [3:0] n, input logic [23:0] v);
      logic [SW-1:0] r;
      r = SW'(v);
      repeat (n) r = r * 74'hA;
      return r;
   endfunction : scaled

   function automatic logic [FW-1:0] expFreq();
      return FW'(expS.start) + FW'(expS.channel) * FW'(expS.step);
   endfunction : expFreq

   task automatic doReset();
      @(negedge sys_clk);
      reset_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      reset_n = 1'b1;
      expS = '{scwd_pkg::PRESET_CHANNEL, scwd_pkg::PRESET_START, scwd_pkg::PRESET_STOP,
               scwd_pkg::PRESET_STEP, scwd_pkg::PRESET_REFERENCE};
      `CHK(settings, expS)
      @(negedge sys_clk);
      `CHK(freqHz, expFreq())
   endtask : doReset

   // Sends one frame, waits for its verdict and compares all settings
   task automatic sendFrame(input logic [3:0] rt, input logic [3:0] ex,
                            input logic [23:0] val, input int nBits, input logic good);
      int w;
      u_scwd_host_model.send({rt, ex, val}, nBits);
      w = 0;
      while (wordAccepted !== 1'b1 && wordDiscarded !== 1'b1 && w < 20)
      begin
         @(negedge sys_clk);
         w++;
      end
      `CHK(wordAccepted, good)
      `CHK(wordDiscarded, ~good)
      `CHK((w >= 3) && (w <= 7), 1'b1)
      if (good)
         case (rt)
            scwd_pkg::RT_CHANNEL:   expS.channel   = scaled(ex, val);
            scwd_pkg::RT_START:     expS.start     = scaled(ex, val);
            scwd_pkg::RT_STOP:      expS.stop      = scaled(ex, val);
            scwd_pkg::RT_STEP:      expS.step      = scaled(ex, val);
            default:                expS.reference = scaled(ex, val);
         endcase
      repeat (2) @(negedge sys_clk);
      `CHK(settings, expS)
      `CHK(freqHz, expFreq())
      repeat (10) @(negedge sys_clk);
   endtask : sendFrame

   task automatic final_report();
      if (fails == 0 && totalChecks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report

   initial
   begin
      doReset();
      for (int i = 0; i < 6; i++)
         sendFrame(RTS[i], EXS[i], VLS[i], 32, 1'b1);
      sendFrame(scwd_pkg::RT_START, 4'h0, 24'h1, 0, 1'b0);
      for (int r = 5; r < 16; r++)
         sendFrame(4'(r), 4'h1, 24'h12345, 32, 1'b0);
      sendFrame(scwd_pkg::RT_CHANNEL, 4'h0, 24'h55, 31, 1'b0);
      sendFrame(scwd_pkg::RT_STEP, 4'h0, 24'h55, 33, 1'b0);
      doReset();
      sendFrame(scwd_pkg::RT_CHANNEL, 4'h9, 24'h3, 32, 1'b1);
      final_report();
   end

   initial
   begin
      #500000;
      fails++;
      final_report();
   end

endmodule : scwd_decoder_bench

// >>> scwd_host_model.sv
/*
 * Host side of the chip-select framed serial link: shifts command words out.
 * Assumes the caller leaves enough idle time between frames for decoding.
 */
`timescale 1ns/100ps

module scwd_host_model (
   output logic serClk,
   output logic serData,
   output logic csN
);

   initial
   begin
      serClk  = 1'b0;
      serData = 1'b0;
      csN     = 1'b1;
   end

   // Sends nBits bits, bit 31 first; the link clock runs only inside the frame
   task automatic send(input logic [31:0] word, input int nBits);
      csN = 1'b0;
      #31;
      for (int i = 0; i < nBits; i++)
      begin
         serData = word[31 - (i % 32)];
         #24 serClk = 1'b1;
         #24 serClk = 1'b0;
      end
      #13 csN = 1'b1;
      serData = ~serData;
   endtask : send

endmodule : scwd_host_model

// >>> scwd_pkg.sv
/*
 * Constants and carrier types for the serial command word decoder.
 * Assumes one 50 MHz system clock and a host-driven serial link clock.
 */
package scwd_pkg;

   // Command word layout
   localparam int WORD_BITS  = 32;
   localparam int ROUTE_MSB  = 31;
   localparam int ROUTE_LSB  = 28;
   localparam int EXP_MSB    = 27;
   localparam int EXP_LSB    = 24;
   localparam int VALUE_MSB  = 23;
   localparam int VALUE_LSB  = 0;
   localparam int VALUE_W    = 24;
   localparam int EXP_W      = 4;

   // Widths of scaled settings: 24-bit value times up to 10^15
   localparam int POW_W      = 50;
   localparam int SET_W      = 74;
   localparam int FREQ_W     = 148;
   localparam int CNT_W      = 6;
   localparam int MAX_EXP    = 15;

   localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
   localparam logic [CNT_W-1:0] CNT_SAT  = 6'h21;
   localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;
   localparam logic [CNT_W-1:0] CNT_RST  = 6'h00;

   // Routing codes
   localparam logic [3:0] RT_CHANNEL   = 4'h0;
   localparam logic [3:0] RT_START     = 4'h1;
   localparam logic [3:0] RT_STOP      = 4'h2;
   localparam logic [3:0] RT_STEP      = 4'h3;
   localparam logic [3:0] RT_REFERENCE = 4'h4;

   // Factory presets (arbitrary values)
   localparam logic [SET_W-1:0] PRESET_CHANNEL   = 74'h0;
   localparam logic [SET_W-1:0] PRESET_START     = 74'hBCA6_5E40;
   localparam logic [SET_W-1:0] PRESET_STOP      = 74'hC928_4A80;
   localparam logic [SET_W-1:0] PRESET_STEP      = 74'hF_4240;
   localparam logic [SET_W-1:0] PRESET_REFERENCE = 74'h131_2D00;

   typedef struct packed {
      logic [3:0]         routeCode;
      logic [EXP_W-1:0]   decadeExp;
      logic [VALUE_W-1:0] valueField;
   } scwd_cmd_t;

   typedef struct packed {
      logic [SET_W-1:0] channel;
      logic [SET_W-1:0] start;
      logic [SET_W-1:0] stop;
      logic [SET_W-1:0] step;
      logic [SET_W-1:0] reference;
   } scwd_settings_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_SCALE = 3'h2,
      ST_ROUTE = 3'h4
   } scwd_state_t;

endpackage : scwd_pkg
